// ---- rtl/dac_input_interp_modulator.sv ----
// Dual-channel DAC input ports, divided data clocks, interpolation and modulator
// Functional notes
// - Data clock divides by rate, doubled stuffing; at ratio one the code toggles it at half rate
// - Two-port captures both ports at clock rise
// - Route bit moves data clock to serial pin
// - Data clock invert and drive unchanged
// - One-port: interleaved clock at twice channel rate; at ratio two the code toggles it every cycle, so it runs at channel rate
// - Channel select high steers word to I
// - Polarity bit swaps channel select meaning
// - One-port forbids non-interpolating rate
// - Interleaved invert, drive, pairing unchanged
// - Three half-band stages per channel
// - Code 00 bypasses all interpolation
// - Code 01: 2x, sequence 1, -1
// - Code 10: 4x, sequence 0,1,0,-1
// - Modulation select: off, /2, /4, /8
// - Modulation follows filtering
// - Code 11: 8x, eight-step sequence
// - Zero stuffing inserts midscale after samples
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module dac_input_interp_modulator (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [13:0] P1_DATA_I,
  input wire logic [13:0] P2_DATA_I,
  input wire logic CHANNEL_SELECT_IN_I,
  output logic DATA_RATE_CLOCK_OUT_O,
  output logic SERIAL_DATA_OUT_O,
  output logic INTERLEAVED_CLOCK_OUT_O,
  output logic DATA_CLOCK_DRIVE_O,
  output logic INTERLEAVED_DRIVE_O,
  output logic [13:0] I_DAC_O,
  output logic [13:0] Q_DAC_O
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Cascade of midpoint stages; each stage doubles the rate
  function automatic dac_pkg::samp_t lerp(dac_pkg::samp_t a_in, dac_pkg::samp_t b_in,
                                          logic [2:0] s, logic [1:0] n);
    dac_pkg::samp_t a;
    dac_pkg::samp_t b;
    logic signed [15:0] sum;
    a = a_in;
    b = b_in;
    sum = '0;
    for (int k = 0; k < dac_pkg::NSTAGE; k++) begin
      if (k < int'(n)) begin
        sum = 16'(a) + 16'(b);
        if (s[int'(n) - 1 - k]) begin
          a = dac_pkg::samp_t'(sum >>> 1);
        end else begin
          b = dac_pkg::samp_t'(sum >>> 1);
        end
      end
    end
    return a;
  endfunction

  function automatic dac_pkg::samp_t mod_apply(dac_pkg::samp_t x, logic [1:0] sel,
                                               logic [2:0] m);
    logic signed [24:0] prod;
    dac_pkg::samp_t k;
    dac_pkg::samp_t r;
    prod = 25'(x) * dac_pkg::K0707;
    k = dac_pkg::samp_t'(prod >>> dac_pkg::K_SHIFT);
    r = x;
    unique case (sel)
      dac_pkg::MOD_OFF: r = x;
      dac_pkg::MOD_2: r = m[0] ? -x : x;
      dac_pkg::MOD_4: begin
        unique case (m[1:0])
          2'h1: r = x;
          2'h3: r = -x;
          default: r = '0;
        endcase
      end
      dac_pkg::MOD_8: begin
        unique case (m)
          3'h1, 3'h3, 3'h7: r = k;
          3'h2: r = x;
          3'h5: r = -k;
          3'h6: r = -x;
          default: r = '0;
        endcase
      end
    endcase
    return r;
  endfunction

  // Clamp and convert to offset binary; midscale is signed zero
  function automatic logic [13:0] to_dac(dac_pkg::samp_t v);
    dac_pkg::samp_t c;
    c = v;
    if (v > dac_pkg::MAX_POS) begin
      c = dac_pkg::MAX_POS;
    end else if (v < dac_pkg::MIN_NEG) begin
      c = dac_pkg::MIN_NEG;
    end
    return {~c[13], c[12:0]};
  endfunction
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [7:0] r_interp, r_port, r_route, next_interp, next_port, next_route;
  logic next_ack, stuffed, to_i;
  logic [31:0] next_rdat;
  logic [5:0] idx;
  logic [2:0] m, next_m;
  dac_pkg::cfg_t cfg, cfg_q;
  always_comb begin
    idx = WB_ADR_I[7:dac_pkg::ADR_LSB];
    next_interp = r_interp;
    next_port = r_port;
    next_route = r_route;
    next_ack = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    next_rdat = '0;
    // Write lands on the edge where the master sees ack
    if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0]) begin
      unique case (idx)
        dac_pkg::IDX_INTERP: next_interp = WB_DAT_I[7:0];
        dac_pkg::IDX_PORT: next_port = WB_DAT_I[7:0];
        dac_pkg::IDX_ROUTE: next_route = WB_DAT_I[7:0];
        default: ;
      endcase
    end
    if (next_ack && !WB_WE_I) begin
      unique case (idx)
        dac_pkg::IDX_INTERP: next_rdat = {24'h000000, r_interp};
        dac_pkg::IDX_PORT: next_rdat = {24'h000000, r_port};
        dac_pkg::IDX_ROUTE: next_rdat = {24'h000000, r_route};
        dac_pkg::IDX_STATUS: next_rdat = {24'h000000, m, cfg.l2, cfg.one_port,
                                          cfg.zs, cfg.pair};
        default: next_rdat = '0;
      endcase
    end
  end
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      r_interp <= dac_pkg::REG_RESET;
      r_port <= dac_pkg::REG_RESET;
      r_route <= dac_pkg::REG_RESET;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      r_interp <= next_interp;
      r_port <= next_port;
      r_route <= next_route;
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_rdat;
    end
  end

  assign DATA_CLOCK_DRIVE_O = r_port[dac_pkg::DDRIVE_BIT];
  assign INTERLEAVED_DRIVE_O = r_port[dac_pkg::IDRIVE_BIT];
  // ----------------------------------------
  // Clock dividers and capture strobes
  // ----------------------------------------
  logic [4:0] ratio, iper;
  logic [3:0] cnt, next_cnt, slot;
  logic dlev, ilev, next_dlev, next_ilev, next_pin8, next_sdo, next_iclk, chg, chan_stb, word_stb;
  always_comb begin
    cfg.one_port = r_port[dac_pkg::ONEPORT_BIT];
    cfg.pair = r_port[dac_pkg::PAIR_BIT];
    cfg.mod = r_interp[dac_pkg::MOD_HI:dac_pkg::MOD_LO];
    cfg.zs = r_interp[dac_pkg::ZSTUFF_BIT];
    cfg.l2 = r_interp[dac_pkg::INTERP_HI:dac_pkg::INTERP_LO];
    // Non-interpolating code runs as 2x in one-port mode
    if (cfg.one_port && cfg.l2 == dac_pkg::L2_1X) begin
      cfg.l2 = dac_pkg::L2_2X;
    end
  end

  always_comb begin
    chg = cfg != cfg_q;
    ratio = 5'(5'h01 << cfg.l2) << cfg.zs;
    iper = ratio >> 1;
    chan_stb = cnt == 4'h0;
    word_stb = cfg.one_port && ((cnt & iper[3:0] - 4'h1) == 4'h0);
    // Restart keeps the clock and the sample slot aligned after a change
    if (chg || 5'(cnt) == ratio - 5'h01) begin
      next_cnt = 4'h0;
    end else begin
      next_cnt = cnt + 4'h1;
    end
    // With a ratio of one a flop can only toggle at half rate
    next_dlev = (ratio == 5'h01) ? ~dlev : (5'(next_cnt) < iper);
    next_ilev = (iper == 5'h01) ? ~ilev : ((next_cnt & iper[3:0] - 4'h1) < (iper[3:0] >> 1));
    next_pin8 = 1'b0;
    next_sdo = 1'b0;
    if (!cfg.one_port) begin
      if (r_route[dac_pkg::ROUTE_BIT]) begin
        next_sdo = next_dlev ^ r_port[dac_pkg::DINV_BIT];
      end else begin
        next_pin8 = next_dlev ^ r_port[dac_pkg::DINV_BIT];
      end
    end
    next_iclk = cfg.one_port & (next_ilev ^ r_port[dac_pkg::IINV_BIT]);
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cnt <= 4'h0;
      dlev <= 1'b0;
      ilev <= 1'b0;
      cfg_q <= '0;
      DATA_RATE_CLOCK_OUT_O <= 1'b0;
      SERIAL_DATA_OUT_O <= 1'b0;
      INTERLEAVED_CLOCK_OUT_O <= 1'b0;
    end else begin
      cnt <= next_cnt;
      dlev <= next_dlev;
      ilev <= next_ilev;
      cfg_q <= cfg;
      DATA_RATE_CLOCK_OUT_O <= next_pin8;
      SERIAL_DATA_OUT_O <= next_sdo;
      INTERLEAVED_CLOCK_OUT_O <= next_iclk;
    end
  end
  // ----------------------------------------
  // Input steering, filters and modulator
  // ----------------------------------------
  dac_pkg::samp_t [1:0] x0, x1, next_x0, next_x1, filt, modo;
  dac_pkg::samp_t hold_i, hold_q, q_prev, next_hold_i, next_hold_q, next_q_prev;
  logic [13:0] dac_i, dac_q, next_dac_i, next_dac_q;
  // Each channel owns its own filter cascade and modulator
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign filt[ch] = lerp(x0[ch], x1[ch], slot[2:0], cfg.l2);
    assign modo[ch] = mod_apply(filt[ch], cfg.mod, m);
  end

  always_comb begin
    slot = cfg.zs ? (cnt >> 1) : cnt;
    stuffed = cfg.zs & cnt[0];
    to_i = CHANNEL_SELECT_IN_I ^ r_port[dac_pkg::IQINV_BIT];
    next_hold_i = hold_i;
    next_hold_q = hold_q;
    next_q_prev = q_prev;
    next_x0 = x0;
    next_x1 = x1;
    if (word_stb) begin
      if (to_i) begin
        next_hold_i = dac_pkg::samp_t'($signed(P1_DATA_I));
      end else begin
        next_hold_q = dac_pkg::samp_t'($signed(P1_DATA_I));
      end
    end
    if (chan_stb) begin
      next_x0 = x1;
      next_q_prev = hold_q;
      if (cfg.one_port) begin
        next_x1[0] = hold_i;
        // Q-first pairing holds Q back one word pair
        next_x1[1] = cfg.pair ? q_prev : hold_q;
      end else begin
        next_x1[0] = dac_pkg::samp_t'($signed(P1_DATA_I));
        next_x1[1] = dac_pkg::samp_t'($signed(P2_DATA_I));
      end
    end
    next_m = chg ? 3'h0 : (stuffed ? m : m + 3'h1);
    next_dac_i = stuffed ? dac_pkg::MIDSCALE : to_dac(modo[0]);
    next_dac_q = stuffed ? dac_pkg::MIDSCALE : to_dac(modo[1]);
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      x0 <= '0;
      x1 <= '0;
      hold_i <= '0;
      hold_q <= '0;
      q_prev <= '0;
      m <= 3'h0;
      dac_i <= dac_pkg::MIDSCALE;
      dac_q <= dac_pkg::MIDSCALE;
    end else begin
      x0 <= next_x0;
      x1 <= next_x1;
      hold_i <= next_hold_i;
      hold_q <= next_hold_q;
      q_prev <= next_q_prev;
      m <= next_m;
      dac_i <= next_dac_i;
      dac_q <= next_dac_q;
    end
  end

  assign I_DAC_O = dac_i;
  assign Q_DAC_O = dac_q;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence req_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence ack_s;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  bus_ack_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    req_s |=> ack_s) else $error("ack not a single pulse");
  div_ratio_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    !chg |-> 5'(cnt) < ratio && (cnt == 4'h0 || $past(cnt) == cnt - 4'h1))
    else $error("bad divide ratio");
  dclk_rise_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (cnt == 4'h0 && ratio > 5'h01 && !cfg.one_port && !r_route[dac_pkg::ROUTE_BIT]
     && $stable({cfg, r_port, r_route})) |-> DATA_RATE_CLOCK_OUT_O == !r_port[dac_pkg::DINV_BIT])
    else $error("data clock not at its edge on wrap");
  route_pin_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    r_route[dac_pkg::ROUTE_BIT] ##1 r_route[dac_pkg::ROUTE_BIT] |-> !DATA_RATE_CLOCK_OUT_O)
    else $error("clock left on pin while rerouted");
  two_cap_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (chan_stb && !cfg.one_port) |=> x1[1] == dac_pkg::samp_t'($signed($past(P2_DATA_I))))
    else $error("port two not captured");
  iq_steer_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (word_stb && (CHANNEL_SELECT_IN_I ^ r_port[dac_pkg::IQINV_BIT]))
    |=> hold_i == dac_pkg::samp_t'($signed($past(P1_DATA_I))))
    else $error("word not steered to I");
  no_1x_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    cfg.one_port |-> cfg.l2 != dac_pkg::L2_1X) else $error("1x used in one-port");
  bypass_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    cfg.l2 == dac_pkg::L2_1X |-> filt[0] == x0[0]) else $error("bypass filtered");
  stuff_mid_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    stuffed |=> I_DAC_O == dac_pkg::MIDSCALE && Q_DAC_O == dac_pkg::MIDSCALE)
    else $error("stuffed slot not midscale");
  mod_half_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (cfg.mod == dac_pkg::MOD_2 && m[0]) |-> modo[0] == -filt[0])
    else $error("half-rate sign not applied");
  restart_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    chg |=> m == 3'h0 && cnt == 4'h0) else $error("index not restarted");
endmodule

// ---- rtl/dac_pkg.sv ----
// Constants, register layout and types for the DAC input and modulator block
package dac_pkg;
  localparam int DW = 14;
  localparam int ADR_LSB = 2;
  // Register indices; byte address is index times four
  localparam logic [5:0] IDX_INTERP = 6'h01;
  localparam logic [5:0] IDX_PORT = 6'h02;
  localparam logic [5:0] IDX_ROUTE = 6'h03;
  localparam logic [5:0] IDX_STATUS = 6'h06;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Interpolation register fields
  localparam int INTERP_HI = 7;
  localparam int INTERP_LO = 6;
  localparam int MOD_HI = 5;
  localparam int MOD_LO = 4;
  localparam int ZSTUFF_BIT = 3;
  // Port register fields
  localparam int ONEPORT_BIT = 6;
  localparam int DDRIVE_BIT = 5;
  localparam int DINV_BIT = 4;
  localparam int IDRIVE_BIT = 3;
  localparam int IINV_BIT = 2;
  localparam int IQINV_BIT = 1;
  localparam int PAIR_BIT = 0;
  // Route register field
  localparam int ROUTE_BIT = 7;
  // Modulation selections
  localparam logic [1:0] MOD_OFF = 2'h0;
  localparam logic [1:0] MOD_2 = 2'h1;
  localparam logic [1:0] MOD_4 = 2'h2;
  localparam logic [1:0] MOD_8 = 2'h3;
  localparam logic [1:0] L2_1X = 2'h0;
  localparam logic [1:0] L2_2X = 2'h1;
  localparam logic [13:0] MIDSCALE = 14'h2000;
  localparam logic signed [14:0] MAX_POS = 15'sh1fff;
  localparam logic signed [14:0] MIN_NEG = -15'sh2000;
  // 0.707 as 181/256
  localparam logic signed [24:0] K0707 = 25'sh00000b5;
  localparam int K_SHIFT = 8;
  localparam int NSTAGE = 3;

  typedef logic signed [14:0] samp_t;
  typedef struct packed {
    logic [1:0] l2;
    logic [1:0] mod;
    logic zs;
    logic one_port;
    logic pair;
  } cfg_t;
endpackage

// ---- sim/bb_source_model.sv ----
// Baseband source model driving the DAC data ports
`timescale 1ns/1ps
module bb_source_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ilv_clk_i,
  input wire logic [13:0] i_word_i,
  input wire logic [13:0] q_word_i,
  output logic [13:0] p1_o,
  output logic [13:0] p2_o,
  output logic sel_o
);
  logic prev;
  logic phase;
  logic next_phase;
  // Source runs from the full rate converter clock
  always_comb begin
    next_phase = (ilv_clk_i && !prev) ? !phase : phase;
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev <= 1'b0;
      phase <= 1'b1;
    end else begin
      prev <= ilv_clk_i;
      phase <= next_phase;
    end
  end
  // Word and select move together, held a whole period
  assign p1_o = phase ? i_word_i : q_word_i;
  assign p2_o = q_word_i;
  assign sel_o = phase;
endmodule

// ---- sim/dac_input_interp_modulator_tb_top.sv ----
// Self-checking bench for the DAC input, interpolation and modulator block
`timescale 1ns/1ps
module dac_input_interp_modulator_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [13:0] iw = 14'h0100;
  logic [13:0] qw = 14'h0200;
  logic [13:0] p1, p2, idac, qdac;
  logic chsel, dclk, sclk, iclk, ddrv, idrv;
  logic [31:0] v;
  int n_errors = 0;
  int compares = 0;
  int n;
  always #10 clk = ~clk;
  dac_input_interp_modulator dut (
    .REF_CLK_I(clk), .RSTN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .P1_DATA_I(p1), .P2_DATA_I(p2),
    .CHANNEL_SELECT_IN_I(chsel), .DATA_RATE_CLOCK_OUT_O(dclk),
    .SERIAL_DATA_OUT_O(sclk), .INTERLEAVED_CLOCK_OUT_O(iclk),
    .DATA_CLOCK_DRIVE_O(ddrv), .INTERLEAVED_DRIVE_O(idrv),
    .I_DAC_O(idac), .Q_DAC_O(qdac)
  );
  bb_source_model src (
    .clk_i(clk), .rstn_i(rstn), .ilv_clk_i(iclk), .i_word_i(iw),
    .q_word_i(qw), .p1_o(p1), .p2_o(p2), .sel_o(chsel)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Counts: compares=%0d mismatches=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    @(posedge clk);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? dclk : (s == 1 ? sclk : iclk);
  endfunction
  // Rising edges seen in 64 cycles, so period 64/n
  task automatic rises(input int s, output int r);
    logic last, cur;
    r = 0;
    // Skip one edge: the pin still carries the old setting until then
    @(posedge clk);
    last = pick(s);
    repeat (64) begin
      @(posedge clk);
      cur = pick(s);
      if (cur && !last) r++;
      last = cur;
    end
  endtask
  // Counts of two I codes over one full modulator cycle
  task automatic tally(input logic [13:0] a, input logic [13:0] b, input int na,
                       input int nb);
    int ca, cb;
    ca = 0;
    cb = 0;
    repeat (8) begin
      @(posedge clk);
      if (idac === a) ca++;
      if (idac === b) cb++;
    end
    check(ca, na);
    check(cb, nb);
  endtask
  task automatic setup(input logic [7:0] r);
    wb(1'b1, 8'h04, r);
    repeat (60) @(posedge clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int a = 1; a < 4; a++) begin
      wb(1'b0, 8'(a * 4), 8'h00);
      check(v, 32'h0);
    end
    wb(1'b1, 8'h0c, 8'h80);
    wb(1'b0, 8'h0c, 8'h00);
    check(v, 32'h80);
    wb(1'b1, 8'h1c, 8'h5a);
    wb(1'b0, 8'h1c, 8'h00);
    check(v, 32'h0);
    wb(1'b1, 8'h04, 8'h40);
    rises(1, n);
    check(n, 32);
    rises(0, n);
    check(n, 0);
    wb(1'b1, 8'h0c, 8'h00);
    $display("Test registers and routing done");
    for (int c = 0; c < 4; c++) begin
      for (int z = 0; z < 2; z++) begin
        if (c + z > 0) begin
          wb(1'b1, 8'h04, {2'(c), 2'b00, 1'(z), 3'b000});
          rises(0, n);
          check(n, 64 / ((1 << c) << z));
        end
      end
    end
    wb(1'b1, 8'h08, 8'h30);
    check(ddrv, 1'b1);
    check(idrv, 1'b0);
    rises(0, n);
    check(n, 4);
    wb(1'b1, 8'h08, 8'h00);
    $display("Test data clock done");
    setup(8'h40);
    tally(14'h2100, 14'h2000, 8, 0);
    check(qdac, 14'h2200);
    setup(8'h00);
    tally(14'h2100, 14'h2000, 8, 0);
    setup(8'h48);
    tally(14'h2100, 14'h2000, 4, 4);
    setup(8'h50);
    tally(14'h2100, 14'h1f00, 4, 4);
    setup(8'ha0);
    tally(14'h2000, 14'h2100, 4, 2);
    tally(14'h1f00, 14'h20b5, 2, 0);
    setup(8'hf0);
    tally(14'h2000, 14'h2100, 2, 1);
    tally(14'h20b5, 14'h1f4b, 3, 1);
    $display("Test modulator done");
    qw <= 14'h3f00;
    wb(1'b1, 8'h08, 8'h48);
    setup(8'h80);
    check(idrv, 1'b1);
    rises(2, n);
    check(n, 32);
    check(idac, 14'h2100);
    check(qdac, 14'h1f00);
    wb(1'b1, 8'h08, 8'h42);
    repeat (60) @(posedge clk);
    check(idac, 14'h1f00);
    check(qdac, 14'h2100);
    // Q-first pairing and inverted interleaved clock keep the steady values
    wb(1'b1, 8'h08, 8'h47);
    repeat (60) @(posedge clk);
    check(idac, 14'h1f00);
    check(qdac, 14'h2100);
    rises(2, n);
    check(n, 32);
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b0, 8'h18, 8'h00);
    check(v[4:2], 3'b011);
    check(v[0], 1'b1);
    $display("Test one-port done");
    give_verdict();
  end
endmodule
